// File: hw/far_exec_core.sv

`timescale 1ns/100ps
`default_nettype none

module far_exec_core #(
    parameter int PADDR_W = far_exec_pkg::PADDR_W
) (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    // instruction issue
    input wire logic EXEC_I,
    input wire logic [3:0] OPCODE_I,
    input wire logic [2:0] BIT_SEL_I,
    input wire logic [7:0] MEM_DATA_I,
    input wire logic [PADDR_W-1:0] PC_I,
    output logic READY_O,
    output logic SKIP_O,
    // data memory write-back
    output logic MEM_WE_O,
    output logic [7:0] MEM_WDATA_O,
    // program memory table port
    output logic PROG_RD_O,
    output logic [PADDR_W-1:0] PROG_ADDR_O,
    input wire logic [15:0] PROG_WORD_I,
    // core register loads from the rest of the core
    input wire logic WORK_WE_I,
    input wire logic PTR_LOW_WE_I,
    input wire logic PTR_HIGH_WE_I,
    input wire logic [7:0] LOAD_DATA_I,
    // architectural state
    output logic [7:0] WORKING_REGISTER_O,
    output logic [7:0] TABLE_FETCH_HIGH_LATCH_O,
    output logic [7:0] TABLE_POINTER_LOW_O,
    output logic [7:0] TABLE_POINTER_HIGH_O,
    output logic [5:0] FLAGS_O
);
    localparam int PAGE_W = PADDR_W - far_exec_pkg::DATA_W;
    localparam logic [PAGE_W-1:0] LAST_PAGE = '1;

    typedef enum logic [1:0] {
        S_IDLE,
        S_DUMMY,
        S_FETCH
    } state_e;

    state_e state_reg;
    state_e state_next;
    far_exec_pkg::op_e op;
    logic accept;
    logic take_skip;
    logic [7:0] working_register_reg;
    logic [7:0] table_fetch_high_latch_reg;
    logic [7:0] table_pointer_low_reg;
    logic [7:0] table_pointer_high_reg;
    logic [7:0] ptr_low_next;
    logic [5:0] flags_reg;
    logic [7:0] diff;
    logic [7:0] xor_val;
    logic [7:0] swapped;
    logic [5:0] sub_flags;
    logic ready_reg;
    logic skip_reg;
    logic mem_we_reg;
    logic [7:0] mem_wdata_reg;
    logic prog_rd_reg;
    logic [PADDR_W-1:0] prog_addr_reg;

    function automatic logic is_tfetch(input far_exec_pkg::op_e o);
        is_tfetch = (o == far_exec_pkg::OP_TFETCH) || (o == far_exec_pkg::OP_TFETCH_FINAL) ||
                    (o == far_exec_pkg::OP_TFETCH_INC) ||
                    (o == far_exec_pkg::OP_TFETCH_INC_FINAL);
    endfunction

    function automatic logic is_preinc(input far_exec_pkg::op_e o);
        is_preinc = (o == far_exec_pkg::OP_TFETCH_INC) ||
                    (o == far_exec_pkg::OP_TFETCH_INC_FINAL);
    endfunction

    function automatic logic is_final_page(input far_exec_pkg::op_e o);
        is_final_page = (o == far_exec_pkg::OP_TFETCH_FINAL) ||
                        (o == far_exec_pkg::OP_TFETCH_INC_FINAL);
    endfunction

    function automatic logic skip_cond(input far_exec_pkg::op_e o, input logic [7:0] m,
                                       input logic [2:0] b);
        unique case (o)
            far_exec_pkg::OP_SKIP_NONNULL: skip_cond = (m != far_exec_pkg::ZERO_BYTE);
            far_exec_pkg::OP_SKIP_NULL: skip_cond = (m == far_exec_pkg::ZERO_BYTE);
            far_exec_pkg::OP_COPY_SKIP_NULL: skip_cond = (m == far_exec_pkg::ZERO_BYTE);
            far_exec_pkg::OP_SKIP_BIT_CLEAR: skip_cond = ~m[b];
            default: skip_cond = 1'b0;
        endcase
    endfunction

    assign op = far_exec_pkg::op_e'(OPCODE_I);
    assign accept = EXEC_I & ready_reg;
    assign take_skip = accept & skip_cond(op, MEM_DATA_I, BIT_SEL_I);
    assign swapped = {MEM_DATA_I[3:0], MEM_DATA_I[7:4]};
    // the pointer bump happens before the address is formed
    assign ptr_low_next = table_pointer_low_reg + 8'h01;

    far_exec_alu u_alu (
        .work_i(working_register_reg),
        .mem_i(MEM_DATA_I),
        .diff_o(diff),
        .xor_o(xor_val),
        .sub_flags_o(sub_flags)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (accept && is_tfetch(op)) begin
                    state_next = S_FETCH;
                end else if (take_skip) begin
                    state_next = S_DUMMY;
                end else begin
                    state_next = S_IDLE;
                end
            end
            S_DUMMY: state_next = S_IDLE;
            S_FETCH: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_reg <= S_IDLE;
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == S_IDLE);
        end
    end

    // skip pulse marks the start of the inserted dummy cycle
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            skip_reg <= 1'b0;
        end else begin
            skip_reg <= take_skip;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            working_register_reg <= far_exec_pkg::WORK_RESET;
        end else if (accept) begin
            unique case (op)
                far_exec_pkg::OP_SUB: working_register_reg <= diff;
                far_exec_pkg::OP_SWAPA: working_register_reg <= swapped;
                far_exec_pkg::OP_COPY_SKIP_NULL: working_register_reg <= MEM_DATA_I;
                far_exec_pkg::OP_XOR: working_register_reg <= xor_val;
                default: working_register_reg <= working_register_reg;
            endcase
        end else if (WORK_WE_I) begin
            working_register_reg <= LOAD_DATA_I;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flags_reg <= far_exec_pkg::FLAGS_RESET;
        end else if (accept) begin
            unique case (op)
                far_exec_pkg::OP_SUB, far_exec_pkg::OP_SUBM: begin
                    flags_reg <= sub_flags;
                end
                far_exec_pkg::OP_XOR, far_exec_pkg::OP_XORM: begin
                    flags_reg[far_exec_pkg::FLAG_NULL] <= (xor_val == far_exec_pkg::ZERO_BYTE);
                end
                default: flags_reg <= flags_reg;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mem_we_reg <= 1'b0;
            mem_wdata_reg <= far_exec_pkg::ZERO_BYTE;
        end else if (state_reg == S_FETCH) begin
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= PROG_WORD_I[7:0];
        end else if (accept && (op == far_exec_pkg::OP_SUBM)) begin
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= diff;
        end else if (accept && (op == far_exec_pkg::OP_XORM)) begin
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= xor_val;
        end else if (accept && (op == far_exec_pkg::OP_SWAP)) begin
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= swapped;
        end else begin
            mem_we_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            table_fetch_high_latch_reg <= far_exec_pkg::LATCH_RESET;
        end else if (state_reg == S_FETCH) begin
            table_fetch_high_latch_reg <= PROG_WORD_I[15:8];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            table_pointer_low_reg <= far_exec_pkg::PTR_RESET;
        end else if (accept && is_preinc(op)) begin
            table_pointer_low_reg <= ptr_low_next;
        end else if (PTR_LOW_WE_I) begin
            table_pointer_low_reg <= LOAD_DATA_I;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            table_pointer_high_reg <= far_exec_pkg::PTR_RESET;
        end else if (PTR_HIGH_WE_I) begin
            table_pointer_high_reg <= LOAD_DATA_I;
        end
    end

    // the page is the pc page, the last page, or the high pointer
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            prog_rd_reg <= 1'b0;
            prog_addr_reg <= '0;
        end else if (accept && is_tfetch(op)) begin
            prog_rd_reg <= 1'b1;
            if (is_final_page(op)) begin
                prog_addr_reg <= {LAST_PAGE,
                    is_preinc(op) ? ptr_low_next : table_pointer_low_reg};
            end else if (is_preinc(op)) begin
                prog_addr_reg <= {table_pointer_high_reg[PAGE_W-1:0], ptr_low_next};
            end else begin
                prog_addr_reg <= {PC_I[PADDR_W-1:8], table_pointer_low_reg};
            end
        end else begin
            prog_rd_reg <= 1'b0;
        end
    end

    assign READY_O = ready_reg;
    assign SKIP_O = skip_reg;
    assign MEM_WE_O = mem_we_reg;
    assign MEM_WDATA_O = mem_wdata_reg;
    assign PROG_RD_O = prog_rd_reg;
    assign PROG_ADDR_O = prog_addr_reg;
    assign WORKING_REGISTER_O = working_register_reg;
    assign TABLE_FETCH_HIGH_LATCH_O = table_fetch_high_latch_reg;
    assign TABLE_POINTER_LOW_O = table_pointer_low_reg;
    assign TABLE_POINTER_HIGH_O = table_pointer_high_reg;
    assign FLAGS_O = flags_reg;

    property p_nonnull_skip;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && op == far_exec_pkg::OP_SKIP_NONNULL |=>
            SKIP_O == ($past(MEM_DATA_I) != 8'h00);
    endproperty
    a_nonnull_skip: assert property (p_nonnull_skip) else $error("nonnull skip wrong");

    property p_sub_acc;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && op == far_exec_pkg::OP_SUB |=>
            WORKING_REGISTER_O == 8'($past(working_register_reg) - $past(MEM_DATA_I)) &&
            FLAGS_O[far_exec_pkg::FLAG_BORROW] ==
            ($past(working_register_reg) >= $past(MEM_DATA_I));
    endproperty
    a_sub_acc: assert property (p_sub_acc) else $error("subtract result wrong");

    property p_subm_mem;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && op == far_exec_pkg::OP_SUBM |=>
            MEM_WE_O && MEM_WDATA_O == 8'($past(working_register_reg) - $past(MEM_DATA_I)) &&
            $stable(WORKING_REGISTER_O);
    endproperty
    a_subm_mem: assert property (p_subm_mem) else $error("subtract to memory wrong");

    property p_swap_flags;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && (op == far_exec_pkg::OP_SWAP || op == far_exec_pkg::OP_SWAPA) |=>
            $stable(FLAGS_O);
    endproperty
    a_swap_flags: assert property (p_swap_flags) else $error("swap changed flags");

    property p_swapa_acc;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && op == far_exec_pkg::OP_SWAPA |=>
            WORKING_REGISTER_O == {$past(MEM_DATA_I[3:0]), $past(MEM_DATA_I[7:4])} && !MEM_WE_O;
    endproperty
    a_swapa_acc: assert property (p_swapa_acc) else $error("swap to working wrong");

    property p_skip_two_cycles;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        take_skip |=> !READY_O ##1 READY_O;
    endproperty
    a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip not two cycles");

    property p_noskip_one_cycle;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && !take_skip && !is_tfetch(op) |=> READY_O && !SKIP_O;
    endproperty
    a_noskip_one_cycle: assert property (p_noskip_one_cycle) else $error("dummy inserted");

    property p_fetch_latch;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && is_tfetch(op) |=> PROG_RD_O ##1
            (MEM_WE_O && MEM_WDATA_O == $past(PROG_WORD_I[7:0]) &&
             TABLE_FETCH_HIGH_LATCH_O == $past(PROG_WORD_I[15:8]));
    endproperty
    a_fetch_latch: assert property (p_fetch_latch) else $error("table fetch wrong");

    property p_final_page;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && is_final_page(op) |=> PROG_ADDR_O[PADDR_W-1:8] == LAST_PAGE;
    endproperty
    a_final_page: assert property (p_final_page) else $error("final page wrong");

    property p_preinc;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && is_preinc(op) && !PTR_LOW_WE_I |=>
            TABLE_POINTER_LOW_O == 8'($past(table_pointer_low_reg) + 8'h01) &&
            PROG_ADDR_O[7:0] == TABLE_POINTER_LOW_O;
    endproperty
    a_preinc: assert property (p_preinc) else $error("preincrement wrong");

    property p_xor_acc;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        accept && op == far_exec_pkg::OP_XOR |=>
            WORKING_REGISTER_O == ($past(working_register_reg) ^ $past(MEM_DATA_I)) &&
            FLAGS_O[5:1] == $past(flags_reg[5:1]);
    endproperty
    a_xor_acc: assert property (p_xor_acc) else $error("xor wrong");
endmodule

`default_nettype wire

// File: hw/far_exec_alu.sv
`timescale 1ns/100ps
`default_nettype none

package far_exec_pkg;
    // instruction codes presented on the opcode port
    typedef enum logic [3:0] {
        OP_NOP,
        OP_SKIP_NONNULL,
        OP_SUB,
        OP_SUBM,
        OP_SWAP,
        OP_SWAPA,
        OP_SKIP_NULL,
        OP_COPY_SKIP_NULL,
        OP_SKIP_BIT_CLEAR,
        OP_TFETCH,
        OP_TFETCH_FINAL,
        OP_TFETCH_INC,
        OP_TFETCH_INC_FINAL,
        OP_XOR,
        OP_XORM
    } op_e;

    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int PADDR_W = 12;
    localparam int OP_W = 4;
    localparam int BIT_W = 3;
    localparam int NIB_W = 4;
    localparam int FLAG_W = 6;
    // status flag positions
    localparam int FLAG_NULL = 0;
    localparam int FLAG_BORROW = 1;
    localparam int FLAG_HALF_BORROW = 2;
    localparam int FLAG_RANGE = 3;
    localparam int FLAG_SIGNED_BORROW = 4;
    localparam int FLAG_CHAINED_NULL = 5;
    // reset values
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // cycles an instruction holds the unit busy
    localparam int CYCLES_PLAIN = 1;
    localparam int CYCLES_SKIP = 2;
    localparam int CYCLES_TFETCH = 2;
endpackage

// arithmetic and logic path for the subtract and exclusive-or group
module far_exec_alu (
    // operands
    input wire logic [7:0] work_i,
    input wire logic [7:0] mem_i,
    // results
    output logic [7:0] diff_o,
    output logic [7:0] xor_o,
    output logic [5:0] sub_flags_o
);
    logic [8:0] wide;
    logic [4:0] low;

    always_comb begin
        wide = {1'b0, work_i} - {1'b0, mem_i};
        low = {1'b0, work_i[3:0]} - {1'b0, mem_i[3:0]};
        diff_o = wide[7:0];
        xor_o = work_i ^ mem_i;
        sub_flags_o = far_exec_pkg::FLAGS_RESET;
        sub_flags_o[far_exec_pkg::FLAG_NULL] = (wide[7:0] == far_exec_pkg::ZERO_BYTE);
        // borrow flag is set when no borrow occurs (result zero or positive)
        sub_flags_o[far_exec_pkg::FLAG_BORROW] = ~wide[8];
        sub_flags_o[far_exec_pkg::FLAG_HALF_BORROW] = ~low[4];
        sub_flags_o[far_exec_pkg::FLAG_RANGE] = (work_i[7] ^ mem_i[7]) & (work_i[7] ^ wide[7]);
        // signed compare: set when working >= mem as signed values
        sub_flags_o[far_exec_pkg::FLAG_SIGNED_BORROW] =
            ~(wide[7] ^ ((work_i[7] ^ mem_i[7]) & (work_i[7] ^ wide[7])));
        // without an incoming borrow the chained null equals the plain null
        sub_flags_o[far_exec_pkg::FLAG_CHAINED_NULL] = (wide[7:0] == far_exec_pkg::ZERO_BYTE);
    end
endmodule

`default_nettype wire

// File: tb/far_exec_core_tb.sv
`timescale 1ns/100ps
`default_nettype none

module far_exec_core_tb;
    logic clock, rst_n, exec_en, work_we, ptr_low_we, ptr_high_we;
    logic [3:0] opcode;
    logic [2:0] bit_sel;
    logic [7:0] mem_data, load_data;
    logic [11:0] pc;
    logic [15:0] prog_word;
    logic ready, skip, mem_we, prog_rd;
    logic [7:0] mem_wdata, working, fetch_high, ptr_low, ptr_high;
    logic [11:0] prog_addr;
    logic [5:0] flags, m_flags;
    int n_fail, samples_checked;

    far_exec_core #(.PADDR_W(12)) i_dut (
        .CLOCK_I(clock), .RSTN_I(rst_n), .EXEC_I(exec_en), .OPCODE_I(opcode),
        .BIT_SEL_I(bit_sel), .MEM_DATA_I(mem_data), .PC_I(pc), .READY_O(ready),
        .SKIP_O(skip), .MEM_WE_O(mem_we), .MEM_WDATA_O(mem_wdata), .PROG_RD_O(prog_rd),
        .PROG_ADDR_O(prog_addr), .PROG_WORD_I(prog_word), .WORK_WE_I(work_we),
        .PTR_LOW_WE_I(ptr_low_we), .PTR_HIGH_WE_I(ptr_high_we), .LOAD_DATA_I(load_data),
        .WORKING_REGISTER_O(working), .TABLE_FETCH_HIGH_LATCH_O(fetch_high),
        .TABLE_POINTER_LOW_O(ptr_low), .TABLE_POINTER_HIGH_O(ptr_high), .FLAGS_O(flags)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    // flags expected after working register minus byte
    function automatic logic [5:0] subf(input logic [7:0] a, input logic [7:0] m);
        logic [7:0] d;
        d = a - m;
        subf[0] = (d == 8'h00);
        subf[1] = (a >= m);
        subf[2] = (a[3:0] >= m[3:0]);
        subf[3] = (a[7] != m[7]) && (d[7] != a[7]);
        subf[4] = ($signed(a) >= $signed(m));
        subf[5] = (d == 8'h00);
    endfunction

    // keep leaves the strobe up so the next call issues back to back
    task automatic exec_op(input far_exec_pkg::op_e op, input logic [7:0] m,
                           input logic [2:0] b, input bit keep);
        int i;
        i = 0;
        while (ready !== 1'b1 && i < 10) begin
            @(negedge clock);
            i++;
        end
        if (i >= 10) begin
            n_fail++;
            print_verdict();
        end
        exec_en = 1'b1;
        opcode = op;
        mem_data = m;
        bit_sel = b;
        @(negedge clock);
        if (!keep) begin
            exec_en = 1'b0;
        end
    endtask

    task automatic load(input logic a, input logic t, input logic h, input logic [7:0] d);
        work_we = a;
        ptr_low_we = t;
        ptr_high_we = h;
        load_data = d;
        @(negedge clock);
        work_we = 1'b0;
        ptr_low_we = 1'b0;
        ptr_high_we = 1'b0;
    endtask

    task automatic t_sub();
        logic [7:0] a[4] = '{8'h50, 8'h30, 8'h80, 8'h22};
        logic [7:0] m[4] = '{8'h30, 8'h50, 8'h01, 8'h22};
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = a[i] - m[i];
            m_flags = subf(a[i], m[i]);
            load(1'b1, 1'b0, 1'b0, a[i]);
            exec_op(far_exec_pkg::OP_SUB, m[i], 3'h0, 1'b0);
            chk(16'({mem_we, working}), 16'({1'b0, d}), "sub working");
            chk(16'(flags), 16'(m_flags), "sub flags");
            load(1'b1, 1'b0, 1'b0, a[i]);
            exec_op(far_exec_pkg::OP_SUBM, m[i], 3'h0, 1'b0);
            chk(16'({mem_we, mem_wdata}), 16'({1'b1, d}), "subm write");
            chk(16'(working), 16'(a[i]), "subm working");
            chk(16'(flags), 16'(m_flags), "subm flags");
        end
    endtask

    task automatic t_swap_xor();
        exec_op(far_exec_pkg::OP_SWAP, 8'ha5, 3'h0, 1'b1);
        chk(16'({mem_we, mem_wdata}), 16'({1'b1, 8'h5a}), "swap write");
        chk(16'(flags), 16'(m_flags), "swap flags");
        exec_op(far_exec_pkg::OP_SWAPA, 8'h3c, 3'h0, 1'b0);
        chk(16'({mem_we, working}), 16'({1'b0, 8'hc3}), "swapa working");
        chk(16'(flags), 16'(m_flags), "swapa flags");
        load(1'b1, 1'b0, 1'b0, 8'h5a);
        exec_op(far_exec_pkg::OP_XOR, 8'h5b, 3'h0, 1'b1);
        m_flags[0] = 1'b0;
        chk(16'({mem_we, working}), 16'({1'b0, 8'h01}), "xor working");
        chk(16'(flags), 16'(m_flags), "xor flags");
        exec_op(far_exec_pkg::OP_XORM, 8'h01, 3'h0, 1'b0);
        m_flags[0] = 1'b1;
        chk(16'({mem_we, mem_wdata}), 16'({1'b1, 8'h00}), "xorm write");
        chk(16'({working, 2'b00, flags}), 16'({8'h01, 2'b00, m_flags}), "xorm working");
    endtask

    task automatic t_skip();
        far_exec_pkg::op_e ops[9] = '{far_exec_pkg::OP_SKIP_NONNULL, far_exec_pkg::OP_SKIP_NONNULL,
            far_exec_pkg::OP_SKIP_NULL, far_exec_pkg::OP_SKIP_NULL,
            far_exec_pkg::OP_COPY_SKIP_NULL, far_exec_pkg::OP_COPY_SKIP_NULL,
            far_exec_pkg::OP_SKIP_BIT_CLEAR, far_exec_pkg::OP_SKIP_BIT_CLEAR,
            far_exec_pkg::OP_SKIP_BIT_CLEAR};
        logic [7:0] mv[9] = '{8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h3c, 8'hfb, 8'h04, 8'h7f};
        logic [2:0] bs[9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h7};
        logic sk[9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 9; i++) begin
            exec_op(ops[i], mv[i], bs[i], 1'b0);
            chk(16'(skip), 16'(sk[i]), "skip");
            chk(16'(ready), 16'(!sk[i]), "skip ready");
            chk(16'(flags), 16'(m_flags), "skip flags");
            if (ops[i] == far_exec_pkg::OP_COPY_SKIP_NULL) begin
                chk(16'(working), 16'(mv[i]), "copy working");
            end
            if (sk[i]) begin
                @(negedge clock);
                chk(16'({ready, skip}), 16'h0002, "after dummy");
            end
        end
        // an issue during the dummy cycle must be ignored
        exec_op(far_exec_pkg::OP_COPY_SKIP_NULL, 8'h00, 3'h0, 1'b1);
        chk(16'({skip, ready, working}), 16'({2'b10, 8'h00}), "copy skip");
        opcode = far_exec_pkg::OP_SWAPA;
        mem_data = 8'h5a;
        @(negedge clock);
        exec_en = 1'b0;
        chk(16'({skip, working}), 16'h0000, "refused issue");
    endtask

    task automatic t_fetch();
        far_exec_pkg::op_e ops[4] = '{far_exec_pkg::OP_TFETCH, far_exec_pkg::OP_TFETCH_FINAL,
            far_exec_pkg::OP_TFETCH_INC, far_exec_pkg::OP_TFETCH_INC_FINAL};
        logic [7:0] tp[4] = '{8'h34, 8'h34, 8'h34, 8'hff};
        logic [3:0] pg[4] = '{4'h5, 4'hf, 4'h7, 4'hf};
        logic [15:0] wd[4] = '{16'hbeef, 16'h1234, 16'hc0de, 16'h8001};
        logic [7:0] np;
        pc = 12'h5a0;
        load(1'b0, 1'b0, 1'b1, 8'h37);
        chk(16'(ptr_high), 16'h0037, "high pointer");
        for (int i = 0; i < 4; i++) begin
            np = (i >= 2) ? tp[i] + 8'h01 : tp[i];
            load(1'b0, 1'b1, 1'b0, tp[i]);
            exec_op(ops[i], 8'h00, 3'h0, 1'b0);
            chk(16'({prog_rd, ready}), 16'h0002, "fetch read");
            chk(16'(prog_addr), 16'({pg[i], np}), "fetch addr");
            chk(16'(ptr_low), 16'(np), "fetch pointer");
            prog_word = wd[i];
            @(negedge clock);
            prog_word = ~wd[i];
            chk(16'({mem_we, ready, prog_rd}), 16'h0006, "fetch write");
            chk({fetch_high, mem_wdata}, wd[i], "fetch word");
            chk(16'(flags), 16'(m_flags), "fetch flags");
        end
    endtask

    initial begin
        n_fail = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        exec_en = 1'b0;
        work_we = 1'b0;
        ptr_low_we = 1'b0;
        ptr_high_we = 1'b0;
        opcode = 4'h0;
        bit_sel = 3'h0;
        mem_data = 8'h00;
        load_data = 8'h00;
        pc = 12'h000;
        prog_word = 16'h5aa5;
        m_flags = 6'h00;
        repeat (8) @(negedge clock);
        chk(16'({ready, working, flags}), 16'h0000, "in reset");
        rst_n = 1'b1;
        @(negedge clock);
        chk(16'(ready), 16'h0001, "ready after reset");
        t_sub();
        t_swap_xor();
        t_skip();
        t_fetch();
        print_verdict();
    end
endmodule

`default_nettype wire
